// File: rtl/swr_pkg.sv
/*
  Shared constants for the supply supervisor and watchdog reset block:
  timing figures, control byte layout, watchdog period codes and states.
  Assumes a single 40 MHz clock and no software-visible register bus.
*/
// Notes on behaviour
// [RQ1] Reset output goes active whenever the low-supply input shows supply below threshold.
// [RQ2] After supply recovers, reset stays active 250ms more; a new low restarts it.
// [RQ3] At power-up reset is active at once and held 250ms after supply is stable.
// [RQ4] With watchdog enabled, no restart within the selected period asserts reset.
// [RQ5] SDA falling while SCL high restarts the watchdog; host must do so in time.
// [RQ6] Watchdog period is one of exactly three presets, chosen by a setting.
// [RQ7] The period setting lives in nonvolatile storage and is restored at power-up.
// [RQ8] WP high with the protect-pin enable bit set refuses all control writes.
// [RQ9] Reset pin is open drain, active low or active high per variant.
// [RQ10] The SDA input is always observed, never gated by bus state.
// [RQ11] Reset entry aborts bus transfers, blocks new ones, lets a started NV write finish.
// [RQ12] Two nonvolatile control bits set the period; host may change them unless locked.
// [RQ13] Counters run from the internal clock; watchdog reset holds the same delay.
// [RQ14] Watchdog counter is held clear while reset is active.
package swr_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;

  // Reset stabilisation delay
  localparam int unsigned RST_DELAY_MS  = 250;

  // Watchdog presets in milliseconds
  localparam int unsigned WDT_LONG_MS   = 1400;
  localparam int unsigned WDT_MID_MS    = 600;
  localparam int unsigned WDT_SHORT_MS  = 200;

  localparam int unsigned CNT_W         = 27;

  // Control byte field positions
  localparam int unsigned PROTECT_PIN_ENABLE_BIT = 7;
  localparam int unsigned WATCHDOG_PERIOD_HIGH_BIT = 6;
  localparam int unsigned WATCHDOG_PERIOD_LOW_BIT  = 5;

  // Stored setting: {protect enable, period high, period low}
  localparam int unsigned CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  typedef enum logic [1:0] {
    SWR_WD_LONG  = 2'h0,
    SWR_WD_MID   = 2'h1,
    SWR_WD_SHORT = 2'h2,
    SWR_WD_OFF   = 2'h3
  } swr_wd_code_t;

  typedef enum logic [2:0] {
    SWR_ST_LOAD = 3'h1,
    SWR_ST_HOLD = 3'h2,
    SWR_ST_RUN  = 3'h4
  } swr_state_t;

endpackage : swr_pkg

// File: rtl/swr_start_det.sv
/*
  Start-condition detector on the two-wire bus lines.
  Assumes SDA and SCL already synchronous to sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module swr_start_det (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      start_o
);

  typedef struct packed {
    logic scl;
    logic sda;
  } swr_sd_state_t;

  swr_sd_state_t s_q;
  swr_sd_state_t s_d;

  always_comb begin
    s_d     = s_q;
    // SDA is sampled every cycle whatever the bus is doing [RQ10]
    s_d.scl = scl_i;
    s_d.sda = sda_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q <= '{scl: 1'b1, sda: 1'b1};
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // Falling SDA with SCL high in both samples [RQ5]
  assign start_o = clk_en_i & s_q.scl & scl_i & s_q.sda & ~sda_i;

endmodule : swr_start_det

`default_nettype wire

// File: rtl/swr_cnt.sv
/*
  Up counter with clear and terminal flag, used for the reset delay and
  for the watchdog. Assumes limit_i is at least one.
*/
`timescale 1ns/1ps
`default_nettype none

module swr_cnt (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     clear_i,
  input  wire logic                     run_i,
  input  wire logic [swr_pkg::CNT_W-1:0] limit_i,
  output logic                          done_o
);

  typedef struct packed {
    logic [swr_pkg::CNT_W-1:0] cnt;
  } swr_cnt_state_t;

  swr_cnt_state_t s_q;
  swr_cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clear_i) begin
      s_d.cnt = '0;
    end else if (run_i && (s_q.cnt < limit_i)) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign done_o = (s_q.cnt >= limit_i);

endmodule : swr_cnt

`default_nettype wire

// File: rtl/swr_supervisor.sv
/*
  Supply supervisor with watchdog reset and the stored watchdog setting.
  Assumes low_supply_i comes from a comparator already synchronous to the
  clock, that the nonvolatile cells sit outside and present their content
  on nv_cfg_i, and that a bus front end hands control byte writes in on
  cfg_wr_i. reset_i is the power-on reset of the internal logic.
*/
`timescale 1ns/1ps
`default_nettype none

module swr_supervisor #(
  parameter bit                     RST_ACTIVE_HIGH = 1'b0,
  parameter logic [swr_pkg::CNT_W-1:0] RST_DELAY_CYC =
    swr_pkg::CNT_W'(swr_pkg::RST_DELAY_MS * swr_pkg::CLK_PER_MS),
  parameter logic [swr_pkg::CNT_W-1:0] WDT_LONG_CYC =
    swr_pkg::CNT_W'(swr_pkg::WDT_LONG_MS * swr_pkg::CLK_PER_MS),
  parameter logic [swr_pkg::CNT_W-1:0] WDT_MID_CYC =
    swr_pkg::CNT_W'(swr_pkg::WDT_MID_MS * swr_pkg::CLK_PER_MS),
  parameter logic [swr_pkg::CNT_W-1:0] WDT_SHORT_CYC =
    swr_pkg::CNT_W'(swr_pkg::WDT_SHORT_MS * swr_pkg::CLK_PER_MS)
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  input  wire logic                     clk_en_i,
  input  wire logic                     low_supply_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  input  wire logic                     wp_i,
  input  wire logic                     cfg_wr_i,
  input  wire logic [7:0]               cfg_wr_data_i,
  input  wire logic [swr_pkg::CFG_W-1:0] nv_cfg_i,
  input  wire logic                     nv_busy_i,
  output logic                          cfg_wr_ack_o,
  output logic                          cfg_wr_nak_o,
  output logic                          nv_wr_o,
  output logic [swr_pkg::CFG_W-1:0]     nv_wr_data_o,
  output logic [swr_pkg::CFG_W-1:0]     cfg_o,
  output logic                          bus_enable_o,
  output logic                          xfer_abort_o,
  output logic                          rst_active_o,
  output logic                          rst_pin_o,
  output logic                          rst_pin_oe_n_o
);

  typedef struct packed {
    swr_pkg::swr_state_t          state;
    logic [swr_pkg::CFG_W-1:0]    cfg;
    logic                         ack;
    logic                         nak;
    logic                         nv_wr;
    logic [swr_pkg::CFG_W-1:0]    nv_data;
    logic                         abort;
  } swr_top_state_t;

  swr_top_state_t s_q;
  swr_top_state_t s_d;

  logic                      start_pulse;
  logic                      delay_done;
  logic                      wdt_done;
  logic                      wdt_enabled;
  logic                      wr_locked;
  logic                      in_reset;
  logic [swr_pkg::CNT_W-1:0] wdt_limit;
  swr_pkg::swr_wd_code_t     wd_code;

  assign in_reset = (s_q.state != swr_pkg::SWR_ST_RUN);

  // Period comes from the two stored control bits [RQ12]
  assign wd_code = swr_pkg::swr_wd_code_t'({
                     s_q.cfg[1], s_q.cfg[0]});

  always_comb begin
    // Exactly three presets plus off, no continuous trim [RQ6]
    case (wd_code)
      swr_pkg::SWR_WD_LONG:  wdt_limit = WDT_LONG_CYC;
      swr_pkg::SWR_WD_MID:   wdt_limit = WDT_MID_CYC;
      swr_pkg::SWR_WD_SHORT: wdt_limit = WDT_SHORT_CYC;
      default:               wdt_limit = WDT_LONG_CYC;
    endcase
  end

  assign wdt_enabled = (wd_code != swr_pkg::SWR_WD_OFF);

  // WP high together with the stored enable bit locks the control byte [RQ8]
  assign wr_locked = wp_i & s_q.cfg[2];

  swr_start_det u_start (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .start_o   (start_pulse)
  );

  // Delay restarts on every low-supply sample and only runs in hold [RQ2] [RQ13]
  swr_cnt u_delay (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (low_supply_i | (s_q.state != swr_pkg::SWR_ST_HOLD)),
    .run_i     (1'b1),
    .limit_i   (RST_DELAY_CYC),
    .done_o    (delay_done)
  );

  // Held clear during reset, restarted by a start condition [RQ14] [RQ5]
  swr_cnt u_wdt (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .clear_i   (in_reset | start_pulse | ~wdt_enabled),
    .run_i     (1'b1),
    .limit_i   (wdt_limit),
    .done_o    (wdt_done)
  );

  always_comb begin
    s_d       = s_q;
    s_d.ack   = 1'b0;
    s_d.nak   = 1'b0;
    s_d.nv_wr = 1'b0;
    s_d.abort = 1'b0;
    case (s_q.state)
      swr_pkg::SWR_ST_LOAD: begin
        // Setting restored from the nonvolatile cells after power-up [RQ7]
        s_d.cfg   = nv_cfg_i;
        s_d.state = swr_pkg::SWR_ST_HOLD;
        // Reset is still active here, so a write must be answered with a refusal [RQ11]
        if (cfg_wr_i) begin
          s_d.nak = 1'b1;
        end
      end
      swr_pkg::SWR_ST_HOLD: begin
        // Active from power-up until supply good for the full delay [RQ3] [RQ1]
        if (!low_supply_i && delay_done) begin
          s_d.state = swr_pkg::SWR_ST_RUN;
        end
        // Writes refused while reset is active [RQ11]
        if (cfg_wr_i) begin
          s_d.nak = 1'b1;
        end
      end
      swr_pkg::SWR_ST_RUN: begin
        if (low_supply_i || (wdt_enabled && wdt_done)) begin
          // Enter reset, cut off the transfer; a pending NV write is not touched [RQ1] [RQ4] [RQ11]
          s_d.state = swr_pkg::SWR_ST_HOLD;
          s_d.abort = 1'b1;
          s_d.nak   = cfg_wr_i;
        end else if (cfg_wr_i) begin
          if (wr_locked || nv_busy_i) begin
            s_d.nak = 1'b1; // [RQ8]
          end else begin
            s_d.cfg     = {cfg_wr_data_i[swr_pkg::PROTECT_PIN_ENABLE_BIT],
                           cfg_wr_data_i[swr_pkg::WATCHDOG_PERIOD_HIGH_BIT],
                           cfg_wr_data_i[swr_pkg::WATCHDOG_PERIOD_LOW_BIT]};
            s_d.nv_data = s_d.cfg;
            s_d.nv_wr   = 1'b1; // [RQ7] [RQ12]
            s_d.ack     = 1'b1;
          end
        end
      end
      default: begin
        s_d.state = swr_pkg::SWR_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      s_q <= '{state:   swr_pkg::SWR_ST_LOAD,
               cfg:     swr_pkg::CFG_RESET,
               ack:     1'b0,
               nak:     1'b0,
               nv_wr:   1'b0,
               nv_data: swr_pkg::CFG_RESET,
               abort:   1'b0};
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  assign cfg_wr_ack_o = s_q.ack;
  assign cfg_wr_nak_o = s_q.nak;
  assign nv_wr_o      = s_q.nv_wr;
  assign nv_wr_data_o = s_q.nv_data;
  assign cfg_o        = s_q.cfg;
  assign bus_enable_o = ~in_reset; // [RQ11]
  assign xfer_abort_o = s_q.abort;
  assign rst_active_o = in_reset;

  // Open drain: only ever pulls low; polarity fixed by variant [RQ9]
  assign rst_pin_o      = 1'b0;
  assign rst_pin_oe_n_o = RST_ACTIVE_HIGH ? in_reset : ~in_reset;

endmodule : swr_supervisor

`default_nettype wire

// File: dv/swr_monitor.sv
/* Port checker for swr_supervisor.
   Assumes a bind onto the supervisor that hands on its count parameters. */
`timescale 1ns/1ps
`default_nettype none
module swr_monitor #(
  parameter bit          RST_ACTIVE_HIGH = 1'b0,
  parameter int unsigned RST_DELAY_CYC   = 20,
  parameter int unsigned WDT_LONG_CYC    = 60,
  parameter int unsigned WDT_MID_CYC     = 40,
  parameter int unsigned WDT_SHORT_CYC   = 30
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       clk_en_i,
  input wire logic       low_supply_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       wp_i,
  input wire logic       cfg_wr_i,
  input wire logic [7:0] cfg_wr_data_i,
  input wire logic [2:0] nv_cfg_i,
  input wire logic       cfg_wr_ack_o,
  input wire logic       cfg_wr_nak_o,
  input wire logic       nv_wr_o,
  input wire logic [2:0] nv_wr_data_o,
  input wire logic [2:0] cfg_o,
  input wire logic       bus_enable_o,
  input wire logic       xfer_abort_o,
  input wire logic       rst_active_o,
  input wire logic       rst_pin_o,
  input wire logic       rst_pin_oe_n_o
);
  logic [7:0]  hc_q, wd_q;
  logic        scl_q, sda_q;
  int unsigned lim;
  always_comb begin
    lim = (cfg_o[1:0] == 2'h0) ? WDT_LONG_CYC : (cfg_o[1:0] == 2'h1) ? WDT_MID_CYC : WDT_SHORT_CYC;
  end
  // Cycles of reset since its last cause, and cycles without a start condition
  always_ff @(posedge sys_clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    hc_q  <= (reset_i || low_supply_i || !rst_active_o) ? 8'h0 : hc_q + 8'h1;
    wd_q  <= (reset_i || rst_active_o || cfg_o[1:0] == 2'h3 || (scl_q && scl_i && sda_q && !sda_i)) ? 8'h0 : wd_q + 8'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_take; cfg_wr_i && clk_en_i; endsequence
  sequence s_locked; rst_active_o || (wp_i && cfg_o[2]); endsequence
  chk_low_asserts: assert property (low_supply_i |=> rst_active_o) else $error("reset not active on low supply");
  chk_hold_min: assert property ($fell(rst_active_o) |-> hc_q >= RST_DELAY_CYC) else $error("reset released early");
  chk_hold_max: assert property (rst_active_o |-> hc_q <= RST_DELAY_CYC + 4) else $error("reset held too long");
  chk_wdt_late: assert property (!rst_active_o |-> wd_q <= lim + 3) else $error("watchdog did not expire");
  chk_wdt_early: assert property ($rose(rst_active_o) && !$past(low_supply_i) |-> wd_q + 3 >= lim) else $error("watchdog expired early");
  chk_abort_entry: assert property (xfer_abort_o == $rose(rst_active_o)) else $error("abort pulse wrong");
  chk_pin_level: assert property (rst_pin_o == 1'b0 && rst_pin_oe_n_o == (rst_active_o ~^ RST_ACTIVE_HIGH)) else $error("reset pin wrong");
  chk_wr_answer: assert property (s_take |=> cfg_wr_ack_o ^ cfg_wr_nak_o) else $error("write not answered once");
  chk_wr_lock: assert property (s_take ##0 s_locked |=> cfg_wr_nak_o && $stable(cfg_o)) else $error("locked write taken");
  chk_wr_store: assert property (s_take ##1 cfg_wr_ack_o |-> nv_wr_o && nv_wr_data_o == cfg_o && cfg_o == $past(cfg_wr_data_i[7:5])) else $error("write not stored");
  chk_bus_block: assert property (bus_enable_o == !rst_active_o) else $error("bus enabled in reset");
  chk_nv_restore: assert property ($past(reset_i) |=> cfg_o == $past(nv_cfg_i)) else $error("setting not restored");
endmodule : swr_monitor
`default_nettype wire

// File: dv/swr_host_model.sv
/* Host on the two-wire bus that restarts the watchdog with start conditions.
   Assumes pull-ups hold both lines high when released. */
`timescale 1ns/1ps
`default_nettype none
module swr_host_model (
  input  wire logic sys_clk_i,
  input  wire logic kick_i,
  input  wire logic hold_low_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic [3:0] ph;
  logic       scl_nxt;
  logic       sda_nxt;
  // Controls are taken at the edge so the bench's own updates never race the model
  initial begin
    ph    = 4'h0;
    scl_o = 1'b1;
    sda_o = 1'b1;
    forever begin
      @(posedge sys_clk_i);
      ph      = (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      scl_nxt = !(kick_i && ph == 4'h7);
      sda_nxt = hold_low_i ? 1'b0 : (!kick_i || ph < 4'h5); // SDA falls at phase 5 with SCL high
      #2;
      scl_o = scl_nxt;
      sda_o = sda_nxt;
    end
  end
endmodule : swr_host_model
`default_nettype wire

// File: dv/tb_top.sv
/* Self-checking bench for swr_supervisor with short counts.
   Assumes the host model and the port checker alongside. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int D = 20;
  localparam int LIM [3] = '{60, 40, 30};
  logic       sys_clk_i, reset_i, low_supply_i, wp_i, cfg_wr_i, nv_busy_i, kick, hold_low, scl, sda;
  logic       ack, nak, nv_wr, bus_en, abort, rst_act, rst_pin, oe_n, oe_n_hi;
  logic [7:0] wr_data;
  logic [2:0] nv_cfg, nv_wr_data, cfg;
  int         fails = 0, compares = 0, n;
  swr_host_model host (.sys_clk_i(sys_clk_i), .kick_i(kick), .hold_low_i(hold_low), .scl_o(scl), .sda_o(sda));
  swr_supervisor #(.RST_DELAY_CYC(27'd20), .WDT_LONG_CYC(27'd60), .WDT_MID_CYC(27'd40), .WDT_SHORT_CYC(27'd30)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .low_supply_i(low_supply_i), .scl_i(scl),
    .sda_i(sda), .wp_i(wp_i), .cfg_wr_i(cfg_wr_i), .cfg_wr_data_i(wr_data), .nv_cfg_i(nv_cfg),
    .nv_busy_i(nv_busy_i), .cfg_wr_ack_o(ack), .cfg_wr_nak_o(nak), .nv_wr_o(nv_wr), .nv_wr_data_o(nv_wr_data),
    .cfg_o(cfg), .bus_enable_o(bus_en), .xfer_abort_o(abort), .rst_active_o(rst_act), .rst_pin_o(rst_pin),
    .rst_pin_oe_n_o(oe_n));
  // Active-high variant on the same stimulus; only its pin enable is compared
  swr_supervisor #(.RST_ACTIVE_HIGH(1'b1), .RST_DELAY_CYC(27'd20), .WDT_LONG_CYC(27'd60), .WDT_MID_CYC(27'd40),
    .WDT_SHORT_CYC(27'd30)) dut_hi (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1), .low_supply_i(low_supply_i), .scl_i(scl),
    .sda_i(sda), .wp_i(wp_i), .cfg_wr_i(cfg_wr_i), .cfg_wr_data_i(wr_data), .nv_cfg_i(nv_cfg),
    .nv_busy_i(nv_busy_i), .cfg_wr_ack_o(), .cfg_wr_nak_o(), .nv_wr_o(), .nv_wr_data_o(),
    .cfg_o(), .bus_enable_o(), .xfer_abort_o(), .rst_active_o(), .rst_pin_o(),
    .rst_pin_oe_n_o(oe_n_hi));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #2;
  endtask : cyc
  task automatic wait_rst(input logic lvl, input int max);
    n = 0;
    while (rst_act !== lvl && n < max) begin
      cyc(1);
      n++;
    end
    check("rst_active", {7'h0, rst_act}, {7'h0, lvl});
  endtask : wait_rst
  task automatic wr(input logic [7:0] b, input logic ok);
    wr_data = b;
    cfg_wr_i = 1'b1;
    cyc(1);
    cfg_wr_i = 1'b0;
    check("ack", {7'h0, ack}, {7'h0, ok});
    check("nak", {7'h0, nak}, {7'h0, !ok});
    check("nv_wr", {7'h0, nv_wr}, {7'h0, ok});
    // One idle edge so a following write never re-raises the strobe in this time step
    cyc(1);
  endtask : wr
  task automatic t_power;
    check("rst_active", {7'h0, rst_act}, 8'h1);
    check("oe_n", {7'h0, oe_n}, 8'h0);
    check("oe_n_hi", {7'h0, oe_n_hi}, 8'h1);
    check("cfg", {5'h0, cfg}, 8'h3);
    wr(8'h00, 1'b0);
    low_supply_i = 1'b0;
    cyc(D - 1);
    check("rst_active", {7'h0, rst_act}, 8'h1);
    wait_rst(1'b0, 8);
    check("oe_n", {7'h0, oe_n}, 8'h1);
    check("oe_n_hi", {7'h0, oe_n_hi}, 8'h0);
  endtask : t_power
  task automatic t_brown;
    low_supply_i = 1'b1;
    cyc(1);
    check("abort", {7'h0, abort}, 8'h1);
    check("rst_active", {7'h0, rst_act}, 8'h1);
    low_supply_i = 1'b0;
    cyc(10);
    low_supply_i = 1'b1;
    cyc(1);
    low_supply_i = 1'b0;
    cyc(D - 1);
    check("rst_active", {7'h0, rst_act}, 8'h1);
    wait_rst(1'b0, 8);
  endtask : t_brown
  task automatic t_protect;
    wr(8'hE0, 1'b1);
    wp_i = 1'b1;
    wr(8'h40, 1'b0);
    check("cfg", {5'h0, cfg}, 8'h7);
    wp_i = 1'b0;
    nv_busy_i = 1'b1;
    wr(8'h60, 1'b0);
    nv_busy_i = 1'b0;
    wr(8'h60, 1'b1);
    wp_i = 1'b1;
    wr(8'h20, 1'b1);
    wr(8'h60, 1'b1);
    wp_i = 1'b0;
    check("nv_data", {5'h0, nv_wr_data}, 8'h3);
    cyc(200);
    check("rst_active", {7'h0, rst_act}, 8'h0);
  endtask : t_protect
  task automatic t_wdog;
    for (int c = 0; c < 3; c++) begin
      kick = 1'b1;
      wr({1'b0, 2'(c), 5'h0}, 1'b1);
      cyc(3 * LIM[c]);
      check("rst_active", {7'h0, rst_act}, 8'h0);
      hold_low = c[0];
      kick = 1'b0;
      wait_rst(1'b1, LIM[c] + 10);
      check("wdt_span", {7'h0, n >= LIM[c] - 12 && n <= LIM[c] + 4}, 8'h1);
      wait_rst(1'b0, D + 6);
      check("wdt_hold", {7'h0, n >= D && n <= D + 4}, 8'h1);
      hold_low = 1'b0;
    end
  endtask : t_wdog
  task automatic stop_test;
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  // Whole run is near 860 cycles; allow well beyond it
  initial begin
    #200000;
    fails++;
    stop_test();
  end
  initial begin
    {reset_i, low_supply_i, wp_i, cfg_wr_i, nv_busy_i, kick, hold_low} = 7'h60;
    wr_data = 8'h00;
    nv_cfg = 3'h3;
    cyc(2);
    reset_i = 1'b0;
    cyc(2);
    t_power();
    t_brown();
    t_protect();
    t_wdog();
    stop_test();
  end
endmodule : tb_top
bind swr_supervisor swr_monitor #(.RST_ACTIVE_HIGH(RST_ACTIVE_HIGH), .RST_DELAY_CYC(RST_DELAY_CYC),
  .WDT_LONG_CYC(WDT_LONG_CYC), .WDT_MID_CYC(WDT_MID_CYC), .WDT_SHORT_CYC(WDT_SHORT_CYC)) u_mon (.sys_clk_i,
  .reset_i, .clk_en_i, .low_supply_i, .scl_i, .sda_i, .wp_i, .cfg_wr_i, .cfg_wr_data_i, .nv_cfg_i, .cfg_wr_ack_o,
  .cfg_wr_nak_o, .nv_wr_o, .nv_wr_data_o, .cfg_o, .bus_enable_o, .xfer_abort_o, .rst_active_o, .rst_pin_o,
  .rst_pin_oe_n_o);
`default_nettype wire
